// [rtl/ppm_pkg.sv]
// Notes on behaviour
// - select field 1x00 picks output 0, onward
// - hardware-owned output overrides software selection
// - debug enabled if debug reset high at por
// - port7 bit0: timer3, timer6 outputs, jtag out
// - port7 bit0 feeds trigger2 in1, can4 rx
// - port6 bit0: mux0, can2 tx, break out
// - port6 bit1: mux1, timer3 out, serial1 data
// - port6 bits feed converter, serial, can2, trigger
// - port2 bit0: can5 tx; feeds can0, timer5
// - port15 and port5 are input only
// - jtag data/mode inputs from port5 bits 2,4
// - port5 bit8 feeds run controls, serial2 ch0
// - port5 bit10 feeds break, serial2 ch1, t13
// - port15 bit4 timer6; port5 bit15 can2
package ppm_pkg;
   // =====================================================
   // select field
   // =====================================================
   localparam int SEL_W = 4;
   localparam logic [1:0] SEL_ALT_POS = 2'h2;
   localparam logic [3:0] SEL_RESET = 4'h0;
   localparam int SYNC_STAGES = 2;
   localparam int SEL_DRIVE_BIT = 3;
   localparam int SEL_NUM_W = 2;
   localparam logic [1:0] POR_FLUSH = 2'(SYNC_STAGES + 1); // edges until synced pins are real
   localparam int PIN_N = 4;
   localparam int P5_N = 16;
   localparam int P15_N = 8;

   typedef logic [SEL_W-1:0] ppm_sel_t;

   // selection per bidirectional pin: port7.0, port6.0, port6.1, port2.0
   typedef struct packed {
      ppm_sel_t port7Bit0;
      ppm_sel_t port6Bit0;
      ppm_sel_t port6Bit1;
      ppm_sel_t port2Bit0;
   } ppm_sel_s;

   // peripheral output sources
   typedef struct packed {
      logic timer3ToggleOut;
      logic timer6ToggleOut;
      logic analogMuxCtl0;
      logic analogMuxCtl1;
      logic can2TxOut;
      logic can5TxOut;
      logic debugBreakOut;
      logic ser1Ch1DataOut;
      logic jtagDataOut;
      logic jtagDataOutEn;
   } ppm_src_s;

   // peripheral input destinations
   typedef struct packed {
      logic emergTrig2In1;
      logic can4RxIn;
      logic convRequestGateIn;
      logic convRequestTrigIn;
      logic ser1Ch1DataIn;
      logic can2RxInE;
      logic emergTrig1In6;
      logic can0RxIn;
      logic timer5CountGateIn;
      logic timer6CountGateIn;
      logic jtagDataIn;
      logic jtagModeIn;
      logic timer3UpdownIn;
      logic ccT12RunCtlIn;
      logic ccT13RunCtlIn;
      logic ser2Ch0DataIn;
      logic debugBreakIn;
      logic ser2Ch1DataIn;
      logic ccUnit1T13RunIn;
      logic can2RxInF;
   } ppm_dst_s;
endpackage

// [rtl/ppm_sync.sv]
`timescale 1ns/10ps
// two-flop synchroniser, one per bit
module ppm_sync #(
   parameter int W = 1
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] stage1;
   logic [W-1:0] next_stage1;
   logic [W-1:0] next_dout;

   // =====================================================
   // sync chain
   // =====================================================
   // first stage read only by the second
   always_comb
   begin
      next_stage1 = din;
      next_dout = stage1;
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         stage1 <= '0;
         dout <= '0;
      end
      else
      begin
         stage1 <= next_stage1;
         dout <= next_dout;
      end
   end
endmodule

// [rtl/port_pin_function_mux.sv]
`timescale 1ns/10ps
// pin function multiplexer
module port_pin_function_mux (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic powerOnResetIn,
   input wire logic debugResetIn,
   input wire logic factoryTestEnable,
   input wire ppm_pkg::ppm_sel_s outputSelectField,
   input wire logic [ppm_pkg::PIN_N-1:0] gpioOut,
   input wire ppm_pkg::ppm_src_s src,
   input wire logic [ppm_pkg::PIN_N-1:0] pinIn,
   input wire logic [ppm_pkg::P5_N-1:0] port5In,
   input wire logic [ppm_pkg::P15_N-1:0] port15In,
   output logic [ppm_pkg::PIN_N-1:0] pinOut,
   output logic [ppm_pkg::PIN_N-1:0] pinOe,
   output ppm_pkg::ppm_dst_s dst,
   output logic [ppm_pkg::P5_N-1:0] port5Gpi,
   output logic [ppm_pkg::P15_N-1:0] port15Gpi,
   output logic debugEnabled,
   output logic debugSysReset,
   output logic factoryTestMode
);
   localparam int ALLW = ppm_pkg::PIN_N + ppm_pkg::P5_N + ppm_pkg::P15_N + 3;

   logic [ALLW-1:0] syncIn;
   logic [ALLW-1:0] syncOut;
   logic [ppm_pkg::PIN_N-1:0] pinS;
   logic [ppm_pkg::P5_N-1:0] p5S;
   logic [ppm_pkg::P15_N-1:0] p15S;
   logic porS, dbgRstS, testS;
   logic porPrev;
   logic next_porPrev;
   logic [ppm_pkg::PIN_N-1:0] next_pinOut;
   logic [ppm_pkg::PIN_N-1:0] next_pinOe;
   ppm_pkg::ppm_dst_s next_dst;
   logic next_debugEnabled, next_debugSysReset, next_factoryTestMode;
   logic [ppm_pkg::SEL_W-1:0] selArr [ppm_pkg::PIN_N];
   logic [3:0] altArr [ppm_pkg::PIN_N];
   logic [ppm_pkg::PIN_N-1:0] swOut;
   logic [ppm_pkg::PIN_N-1:0] swOe;
   logic [ppm_pkg::P5_N-1:0] next_port5Gpi;
   logic [ppm_pkg::P15_N-1:0] next_port15Gpi;
   logic [1:0] porWarm;
   logic [1:0] next_porWarm;

   // =====================================================
   // input synchronisation
   // =====================================================
   assign syncIn = {pinIn, port5In, port15In, powerOnResetIn, debugResetIn, factoryTestEnable};

   ppm_sync #(.W(ALLW)) u_sync (
      .ref_clk(ref_clk),
      .reset(reset),
      .din(syncIn),
      .dout(syncOut)
   );

   assign {pinS, p5S, p15S, porS, dbgRstS, testS} = syncOut;

   // =====================================================
   // output selection
   // =====================================================
   // per-pin alternate sources indexed by output number 0..3
   assign selArr[3] = outputSelectField.port7Bit0;
   assign selArr[2] = outputSelectField.port6Bit0;
   assign selArr[1] = outputSelectField.port6Bit1;
   assign selArr[0] = outputSelectField.port2Bit0;
   assign altArr[3] = {1'b0, src.timer6ToggleOut, src.timer3ToggleOut, gpioOut[3]};
   assign altArr[2] = {src.debugBreakOut, src.can2TxOut, src.analogMuxCtl0, gpioOut[2]};
   assign altArr[1] = {src.ser1Ch1DataOut, src.timer3ToggleOut, src.analogMuxCtl1, gpioOut[1]};
   assign altArr[0] = {1'b0, 1'b0, src.can5TxOut, gpioOut[0]};

   // decode of select field, one slice per pin
   generate
      for (genvar gi = 0; gi < ppm_pkg::PIN_N; gi++)
      begin : g_pin
         // top bit turns the driver on
         assign swOe[gi] = selArr[gi][ppm_pkg::SEL_DRIVE_BIT];
         assign swOut[gi] = altArr[gi][selArr[gi][ppm_pkg::SEL_NUM_W-1:0]];
      end
   endgenerate

   // software choice first, then the hardware owner of port7 bit0
   always_comb
   begin
      next_pinOe = swOe;
      next_pinOut = swOut;
      if (src.jtagDataOutEn)
      begin
         next_pinOe[3] = 1'b1;
         next_pinOut[3] = src.jtagDataOut;
      end
   end

   // =====================================================
   // input distribution
   // =====================================================
   // levels reach every input always
   always_comb
   begin
      next_dst.emergTrig2In1 = pinS[3];
      next_dst.can4RxIn = pinS[3];
      next_dst.convRequestGateIn = pinS[2];
      next_dst.ser1Ch1DataIn = pinS[2];
      next_dst.convRequestTrigIn = pinS[1];
      next_dst.can2RxInE = pinS[1];
      next_dst.emergTrig1In6 = pinS[1];
      next_dst.can0RxIn = pinS[0];
      next_dst.timer5CountGateIn = pinS[0];
      next_dst.jtagDataIn = p5S[2];
      next_dst.jtagModeIn = p5S[4];
      next_dst.timer3UpdownIn = p5S[4];
      next_dst.ccT12RunCtlIn = p5S[8];
      next_dst.ccT13RunCtlIn = p5S[8];
      next_dst.ser2Ch0DataIn = p5S[8];
      next_dst.debugBreakIn = p5S[10];
      next_dst.ser2Ch1DataIn = p5S[10];
      next_dst.ccUnit1T13RunIn = p5S[10];
      next_dst.timer6CountGateIn = p15S[4];
      next_dst.can2RxInF = p5S[15];
      next_port5Gpi = p5S;
      next_port15Gpi = p15S;
   end

   // =====================================================
   // debug and test pins
   // =====================================================
   // por watch stays blind until the synchroniser has flushed: its
   // stages reset low while the pin idles high, which looks like a rise
   always_comb
   begin
      next_porWarm = porWarm;
      if (porWarm != ppm_pkg::POR_FLUSH)
         next_porWarm = porWarm + 2'h1;
   end

   // strap caught on rising edge of por, clocked; a rise inside the
   // flush window right after reset is not seen
   always_comb
   begin
      next_porPrev = porS;
      next_debugEnabled = debugEnabled;
      if ((porWarm == ppm_pkg::POR_FLUSH) && porS && !porPrev)
         next_debugEnabled = dbgRstS;
      next_debugSysReset = debugEnabled && !dbgRstS;
   end

   // test pin kept apart from the strap logic
   always_comb
   begin
      next_factoryTestMode = !testS;
   end

   // =====================================================
   // registers
   // =====================================================
   // pin drive registered so pads never see decode glitches
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         pinOut <= '0;
         pinOe <= '0;
      end
      else
      begin
         pinOut <= next_pinOut;
         pinOe <= next_pinOe;
      end
   end

   // peripheral inputs and plain inputs
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         dst <= '0;
         port5Gpi <= '0;
         port15Gpi <= '0;
      end
      else
      begin
         dst <= next_dst;
         port5Gpi <= next_port5Gpi;
         port15Gpi <= next_port15Gpi;
      end
   end

   // debug strap state
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         porWarm <= '0;
         porPrev <= 1'b0;
         debugEnabled <= 1'b0;
         debugSysReset <= 1'b0;
      end
      else
      begin
         porWarm <= next_porWarm;
         porPrev <= next_porPrev;
         debugEnabled <= next_debugEnabled;
         debugSysReset <= next_debugSysReset;
      end
   end

   // test pin state
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         factoryTestMode <= 1'b0;
      end
      else
      begin
         factoryTestMode <= next_factoryTestMode;
      end
   end
endmodule

// [testbench/ppm_asserts.sv]
`timescale 1ns/10ps
// =========================
// pin mux checker
// =========================
module ppm_checker (
   input wire logic ref_clk,
   input wire logic reset,
   input wire ppm_pkg::ppm_sel_s outputSelectField,
   input wire logic [3:0] gpioOut,
   input wire ppm_pkg::ppm_src_s src,
   input wire logic [3:0] pinIn,
   input wire logic [15:0] port5In,
   input wire logic [7:0] port15In,
   input wire logic [3:0] pinOut,
   input wire logic [3:0] pinOe,
   input wire ppm_pkg::ppm_dst_s dst,
   input wire logic [15:0] port5Gpi,
   input wire logic [7:0] port15Gpi
);
   logic [1:0] warm;
   logic [1:0] next_warm;
   wire [3:0] s2 = outputSelectField.port2Bit0;
   wire [3:0] s60 = outputSelectField.port6Bit0;
   wire [3:0] s61 = outputSelectField.port6Bit1;
   // pins take three edges to reach peripherals, so wait out the flush
   always_comb next_warm = (warm == 2'h3) ? warm : warm + 2'h1;
   always_ff @(posedge ref_clk) warm <= reset ? 2'h0 : next_warm;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   sequence s_owner;
      src.jtagDataOutEn;
   endsequence
   a_p2_off_idle: assert property (!s2[3] |=> !pinOe[0])
      else $error("deselected pin driven");
   a_p2_gpio_pick: assert property (s2 == 4'h8 |=> pinOe[0] && pinOut[0] == $past(gpioOut[0]))
      else $error("gpio not routed");
   a_p2_can_tx: assert property ({s2[3], s2[1:0]} == 3'h5 |=> pinOut[0] == $past(src.can5TxOut))
      else $error("can5 tx not routed");
   a_hw_owner_drive: assert property (s_owner |=> pinOe[3] && pinOut[3] == $past(src.jtagDataOut))
      else $error("owner lost pin");
   a_p60_break: assert property ({s60[3], s60[1:0]} == 3'h7 |=> pinOut[2] == $past(src.debugBreakOut))
      else $error("break out not routed");
   a_p61_serial: assert property ({s61[3], s61[1:0]} == 3'h7 |=> pinOut[1] == $past(src.ser1Ch1DataOut))
      else $error("serial out not routed");
   a_gpi_delay: assert property (warm == 2'h3 |-> {port5Gpi, port15Gpi} == $past({port5In, port15In}, 3))
      else $error("gpi wrong");
   a_p7_fanout: assert property (warm == 2'h3 |-> {dst.emergTrig2In1, dst.can4RxIn} == {2{$past(pinIn[3], 3)}})
      else $error("port7 input fanout wrong");
endmodule
bind port_pin_function_mux ppm_checker u_chk (.ref_clk, .reset, .outputSelectField, .gpioOut,
   .src, .pinIn, .port5In, .port15In, .pinOut, .pinOe, .dst, .port5Gpi, .port15Gpi);

// [testbench/ppm_partner.sv]
`timescale 1ns/10ps
// =========================
// board and peripheral model
// =========================
module ppm_partner (
   input wire logic ref_clk,
   input wire logic jtagEn,
   input wire logic [3:0] extLevel,
   input wire logic factoryTestReq,
   input wire logic [3:0] pinOut,
   input wire logic [3:0] pinOe,
   output ppm_pkg::ppm_src_s src,
   output logic [3:0] pinIn,
   output logic factoryTestEnable
);
   logic [8:0] cnt = 9'h0A5;
   // sources shift every cycle so a stale selection shows at once
   always @(negedge ref_clk) cnt <= {cnt[7:0], cnt[8] ^ cnt[4]};
   assign src = {cnt, jtagEn};
   // wire level: the mux wins while driving, else the board level
   assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
   // test pin kept high unless a factory test is asked for
   assign factoryTestEnable = ~factoryTestReq;
endmodule

// [testbench/testbench.sv]
`timescale 1ns/10ps
module testbench;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic powerOnResetIn = 1'b0;
   // debug strap low in normal use
   logic debugResetIn = 1'b0;
   logic jtagEn = 1'b0;
   logic factoryTestReq = 1'b0;
   logic [3:0] extLevel = 4'h0;
   logic [3:0] gpioOut = 4'h0;
   logic [15:0] port5In = 16'h0000;
   logic [7:0] port15In = 8'h00;
   ppm_pkg::ppm_sel_s outputSelectField = 16'h0000;
   ppm_pkg::ppm_src_s src;
   ppm_pkg::ppm_dst_s dst;
   logic [3:0] pinIn, pinOut, pinOe;
   logic [15:0] port5Gpi;
   logic [7:0] port15Gpi;
   logic factoryTestEnable, debugEnabled, debugSysReset, factoryTestMode;
   int failures = 0;
   int cmp_count = 0;
   port_pin_function_mux DUT (.ref_clk, .reset, .powerOnResetIn, .debugResetIn,
      .factoryTestEnable, .outputSelectField, .gpioOut, .src, .pinIn, .port5In, .port15In,
      .pinOut, .pinOe, .dst, .port5Gpi, .port15Gpi, .debugEnabled, .debugSysReset,
      .factoryTestMode);
   ppm_partner u_partner (.ref_clk, .jtagEn, .extLevel, .factoryTestReq, .pinOut, .pinOe,
      .src, .pinIn, .factoryTestEnable);
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         failures++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict;
      $display("compares=%0d mismatches=%0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // every select code on every pin, owner toggled on and off
   task automatic t_select;
      logic [3:0] c, eOut, eOe;
      logic [3:0] alt [4];
      for (int k = 0; k < 16; k++)
      begin
         c = k[3:0];
         outputSelectField = {c, c, c, c};
         gpioOut = ~c;
         jtagEn = c[2];
         @(posedge ref_clk);
         alt[3] = {1'b0, src.timer6ToggleOut, src.timer3ToggleOut, gpioOut[3]};
         alt[2] = {src.debugBreakOut, src.can2TxOut, src.analogMuxCtl0, gpioOut[2]};
         alt[1] = {src.ser1Ch1DataOut, src.timer3ToggleOut, src.analogMuxCtl1, gpioOut[1]};
         alt[0] = {2'b00, src.can5TxOut, gpioOut[0]};
         for (int i = 0; i < 4; i++)
         begin
            eOe[i] = c[3];
            eOut[i] = c[3] & alt[i][c[1:0]];
         end
         eOe[3] = eOe[3] | jtagEn;
         eOut[3] = jtagEn ? src.jtagDataOut : eOut[3];
         @(negedge ref_clk);
         check(pinOe, eOe); // drive enables
         check(pinOut & pinOe, eOut); // routed values
      end
   endtask
   // complementary pin levels, then pins driven by the mux itself
   task automatic t_inputs;
      logic [3:0] p;
      for (int k = 0; k < 3; k++)
      begin
         port5In = (k == 1) ? 16'h5A3C : 16'hA5C3;
         // levels differ from port5 bit for bit, so crossed buses show
         port15In = ~port5In[7:0];
         extLevel = port5In[7:4];
         outputSelectField = (k == 2) ? 16'h8888 : 16'h0000;
         gpioOut = 4'h6;
         jtagEn = 1'b0;
         p = (k == 2) ? 4'h6 : extLevel;
         repeat (6) @(negedge ref_clk);
         check(dst, {p[3], p[3], p[2], p[1], p[2], p[1], p[1], p[0], p[0], port15In[4],
            port5In[2], {2{port5In[4]}}, {3{port5In[8]}}, {3{port5In[10]}},
            port5In[15]}); // input fanout
         check({port5Gpi, port15Gpi}, {port5In, port15In}); // plain inputs
      end
   endtask
   // strap low then high at the power-on rise, one low pulse, test pin, mid-run reset
   task automatic t_debug;
      powerOnResetIn = 1'b1;
      repeat (6) @(negedge ref_clk);
      check(debugEnabled, 1'b0); // strap low
      check(factoryTestMode, 1'b0); // normal mode
      powerOnResetIn = 1'b0;
      debugResetIn = 1'b1;
      repeat (4) @(negedge ref_clk);
      powerOnResetIn = 1'b1;
      repeat (6) @(negedge ref_clk);
      check({debugEnabled, debugSysReset}, 2'h2); // strap high
      debugResetIn = 1'b0;
      repeat (4) @(negedge ref_clk);
      check(debugSysReset, 1'b1); // pulse low
      debugResetIn = 1'b1;
      repeat (4) @(negedge ref_clk);
      check(debugSysReset, 1'b0); // pulse ends
      factoryTestReq = 1'b1;
      repeat (4) @(negedge ref_clk);
      check(factoryTestMode, 1'b1); // low pin enters test
      factoryTestReq = 1'b0;
      repeat (4) @(negedge ref_clk);
      check(factoryTestMode, 1'b0); // back to normal
      // reset with por and strap high: no por rise, so no strap
      reset = 1'b1;
      repeat (10) @(negedge ref_clk);
      check(debugEnabled, 1'b0); // reset clears strap
      reset = 1'b0;
      repeat (6) @(negedge ref_clk);
      check({debugEnabled, debugSysReset}, 2'h0); // no false por rise
   endtask
   initial forever #25 ref_clk = ~ref_clk;
   initial
   begin
      repeat (10) @(negedge ref_clk);
      reset = 1'b0;
      t_select;
      t_inputs;
      t_debug;
      print_verdict;
   end
   // run needs under two hundred cycles
   initial
   begin
      repeat (2000) @(posedge ref_clk);
      failures++;
      print_verdict;
   end
endmodule
